// *** hisc_irq_ctrl.v ***
// Host-interface interrupt status, enable, set and clear registers
//
// Notes on behaviour
// - Clear bit 26 clears the high-speed UART receive frame error flag.
// - Clear bit 25 clears the buffer reconfigured-while-in-use flag.
// - Clear bit 24 clears the slow system bus on write flag.
// - Clear bit 23 clears the slow system bus on read flag.
// - Clear bit 22 clears the bus error flag.
// - Clear bit 21 clears the fill level reached flag.
// - Clear bits 20..17 clear max-size-exceeded per receive buffer 0..3.
// - Clear bit 16 clears the link CRC error flag.
// - Clear bit 15 clears the transmit inter-character timeout flag.
// - Clear bits 14..11 clear frame overflow per receive buffer 0..3.
// - Clear bits 10..7 clear frame underflow per receive buffer 0..3.
// - Clear bit 6 clears the transmit frame missing on host read flag.
// - Clear bit 5 clears the no receive buffer available flag.
// - Clear bit 4 clears the end of transmit flag.
// - Clear bits 3..0 clear end of receive per receive buffer 0..3.
// - A zero in any clear bit leaves its flag unchanged.
// - Set-status register forces each flag to one where a one is written.
// - Enable register: a written one sets its enable, zero leaves it.
//
// The Avalon-MM register port was left to the implementer.
`default_nettype none

module hisc_irq_ctrl (
  // Clock and reset
  input  wire        clock,
  input  wire        reset_n,
  // Avalon-MM slave
  input  wire [13:0] address,
  input  wire        read,
  input  wire        write,
  input  wire [3:0]  byteenable,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  // Event pulses from buffer and link logic, one per flag
  input  wire [26:0] eventPulse,
  // Interrupt request
  output reg         irqRequest
);

`include "hisc_consts.vh"

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////////////////////

  reg  [26:0] enable_q;
  reg  [26:0] enable_d;
  wire [26:0] status;
  wire [26:0] pending;

  wire        reqActive;
  wire        firstEdge;
  wire        commit;
  wire [31:0] laneMask;
  wire [31:0] wdataMasked;

  wire        hitStatus;
  wire        hitEnSet;
  wire        hitClr;
  wire        hitSet;
  wire        hitEnClr;
  wire        hitPending;

  wire [26:0] clrField;
  reg  [26:0] clrVec;
  wire [26:0] setVec;
  wire [26:0] enSetVec;
  wire [26:0] enClrVec;

  reg  [31:0] readMux;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake
  ////////////////////////////////////////////////////////////////////////////

  // Every access takes exactly one wait cycle, so the master sees a fixed
  // latency; the cost is one extra cycle even for trivially fast registers.
  assign reqActive = read | write;
  assign firstEdge = reqActive & waitrequest;
  assign commit    = write & ~waitrequest;

  always @(posedge clock) begin
    if (!reset_n) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~firstEdge;
    end
  end

  // Byte enables gate each write lane
  assign laneMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                     {8{byteenable[1]}}, {8{byteenable[0]}}};
  assign wdataMasked = writedata & laneMask;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  ////////////////////////////////////////////////////////////////////////////

  assign hitStatus  = (address == `HISC_OFS_STATUS);
  assign hitEnSet   = (address == `HISC_OFS_ENABLE_SET);
  assign hitClr     = (address == `HISC_OFS_CLR_STATUS);
  assign hitSet     = (address == `HISC_OFS_SET_STATUS);
  assign hitEnClr   = (address == `HISC_OFS_ENABLE_CLR);
  assign hitPending = (address == `HISC_OFS_PENDING);

  ////////////////////////////////////////////////////////////////////////////
  // Clear command decode
  ////////////////////////////////////////////////////////////////////////////

  // Reserved bits 31..27 are dropped here and have no effect
  assign clrField = (commit && hitClr) ? wdataMasked[26:0] : 27'h0000000;

  // Each field copies only its ones; zero bits pass no clear
  always @* begin
    clrVec = 27'h0000000;
    clrVec[`HISC_BIT_UART_FER] = clrField[`HISC_BIT_UART_FER];
    clrVec[`HISC_BIT_BUF_RECFG] = clrField[`HISC_BIT_BUF_RECFG];
    clrVec[`HISC_BIT_WR_SLOW] = clrField[`HISC_BIT_WR_SLOW];
    clrVec[`HISC_BIT_RD_SLOW] = clrField[`HISC_BIT_RD_SLOW];
    clrVec[`HISC_BIT_BUS_ERR] = clrField[`HISC_BIT_BUS_ERR];
    clrVec[`HISC_BIT_FILL_HIT] = clrField[`HISC_BIT_FILL_HIT];
    clrVec[`HISC_MSB_MAX_SIZE:`HISC_LSB_MAX_SIZE] =
      clrField[`HISC_MSB_MAX_SIZE:`HISC_LSB_MAX_SIZE];
    clrVec[`HISC_BIT_CRC_FAIL] = clrField[`HISC_BIT_CRC_FAIL];
    clrVec[`HISC_BIT_GAP_TMO] = clrField[`HISC_BIT_GAP_TMO];
    clrVec[`HISC_MSB_FRM_OVER:`HISC_LSB_FRM_OVER] =
      clrField[`HISC_MSB_FRM_OVER:`HISC_LSB_FRM_OVER];
    clrVec[`HISC_MSB_FRM_UNDER:`HISC_LSB_FRM_UNDER] =
      clrField[`HISC_MSB_FRM_UNDER:`HISC_LSB_FRM_UNDER];
    clrVec[`HISC_BIT_TX_MISSING] = clrField[`HISC_BIT_TX_MISSING];
    clrVec[`HISC_BIT_RX_NOBUF] = clrField[`HISC_BIT_RX_NOBUF];
    clrVec[`HISC_BIT_EOT] = clrField[`HISC_BIT_EOT];
    clrVec[`HISC_MSB_EOR:`HISC_LSB_EOR] =
      clrField[`HISC_MSB_EOR:`HISC_LSB_EOR];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Set-status and enable commands
  ////////////////////////////////////////////////////////////////////////////

  assign setVec   = (commit && hitSet) ? wdataMasked[26:0] : 27'h0000000;
  assign enSetVec = (commit && hitEnSet) ? wdataMasked[26:0] : 27'h0000000;
  assign enClrVec = (commit && hitEnClr) ? wdataMasked[26:0] : 27'h0000000;

  always @* begin
    enable_d = (enable_q | enSetVec) & ~enClrVec;
  end

  always @(posedge clock) begin
    if (!reset_n) begin
      enable_q <= `HISC_RST_ENABLE;
    end else begin
      enable_q <= enable_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags
  ////////////////////////////////////////////////////////////////////////////

  hisc_flag_bank uFlags (
    .clock   (clock),
    .reset_n (reset_n),
    .hwSet   (eventPulse),
    .swSet   (setVec),
    .swClear (clrVec),
    .flag    (status)
  );

  assign pending = status & enable_q;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request
  ////////////////////////////////////////////////////////////////////////////

  // Registered, so it trails the flag and enable state by one cycle
  always @(posedge clock) begin
    if (!reset_n) begin
      irqRequest <= 1'b0;
    end else begin
      irqRequest <= |pending;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  ////////////////////////////////////////////////////////////////////////////

  // Clear and set-status registers are write-only and read as zero, as do unmapped words; enable-clear reads the enables
  always @* begin
    readMux = `HISC_RST_RDATA;
    if (hitStatus) begin
      readMux = {5'h00, status};
    end else if (hitEnSet || hitEnClr) begin
      readMux = {5'h00, enable_q};
    end else if (hitPending) begin
      readMux = {5'h00, pending};
    end
  end

  // Captured at the first edge so data stand through the wait-low cycle
  always @(posedge clock) begin
    if (!reset_n) begin
      readdata <= `HISC_RST_RDATA;
    end else if (firstEdge && read) begin
      readdata <= readMux;
    end
  end

endmodule

`default_nettype wire

// *** hisc_consts.vh ***
// Constants for the host-interface interrupt status block
`ifndef HISC_CONSTS_VH
`define HISC_CONSTS_VH

// Bus geometry
`define HISC_ADDR_W          14
`define HISC_DATA_W          32
`define HISC_FLAG_W          27

// Register byte offsets
`define HISC_OFS_STATUS      14'h3FE0
`define HISC_OFS_ENABLE_SET  14'h3FE4
`define HISC_OFS_CLR_STATUS  14'h3FE8
`define HISC_OFS_SET_STATUS  14'h3FEC
`define HISC_OFS_ENABLE_CLR  14'h3FF0
`define HISC_OFS_PENDING     14'h3FF4

// Field positions, shared by status, enable, set and clear layouts
`define HISC_BIT_UART_FER    26
`define HISC_BIT_BUF_RECFG   25
`define HISC_BIT_WR_SLOW     24
`define HISC_BIT_RD_SLOW     23
`define HISC_BIT_BUS_ERR     22
`define HISC_BIT_FILL_HIT    21
`define HISC_MSB_MAX_SIZE    20
`define HISC_LSB_MAX_SIZE    17
`define HISC_BIT_CRC_FAIL    16
`define HISC_BIT_GAP_TMO     15
`define HISC_MSB_FRM_OVER    14
`define HISC_LSB_FRM_OVER    11
`define HISC_MSB_FRM_UNDER   10
`define HISC_LSB_FRM_UNDER   7
`define HISC_BIT_TX_MISSING  6
`define HISC_BIT_RX_NOBUF    5
`define HISC_BIT_EOT         4
`define HISC_MSB_EOR         3
`define HISC_LSB_EOR         0

// Reset values
`define HISC_RST_STATUS      27'h0000000
`define HISC_RST_ENABLE      27'h0000000
`define HISC_RST_RDATA       32'h00000000

`endif

// *** hisc_flag_bank.v ***
// Bank of sticky interrupt status flags with set-over-clear priority
`default_nettype none

module hisc_flag_bank (
  // Clock and reset
  input  wire        clock,
  input  wire        reset_n,
  // Set and clear sources
  input  wire [26:0] hwSet,
  input  wire [26:0] swSet,
  input  wire [26:0] swClear,
  // Flag state
  output wire [26:0] flag
);

`include "hisc_consts.vh"

  reg  [26:0] flag_q;
  wire [26:0] rstFlags;

  assign rstFlags = `HISC_RST_STATUS;
  assign flag     = flag_q;

  genvar i;
  generate
    for (i = 0; i < `HISC_FLAG_W; i = i + 1) begin : gFlag
      // Any set source beats a clear in the same cycle
      always @(posedge clock) begin
        if (!reset_n) begin
          flag_q[i] <= rstFlags[i];
        end else if (hwSet[i] || swSet[i]) begin
          flag_q[i] <= 1'b1;
        end else if (swClear[i]) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// *** hisc_irq_ctrl_properties.sv ***
// Port checks for the interrupt status and clear registers
`default_nettype none
`include "hisc_consts.vh"
module hisc_irq_ctrl_properties (
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // Register bus
  input wire logic [13:0] address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Events and request
  input wire logic [26:0] eventPulse,
  input wire logic        irqRequest
);
  logic commit;
  logic raiseWr;
  logic dropWr;
  assign commit = write && !waitrequest;
  assign raiseWr = commit && (address == `HISC_OFS_ENABLE_SET || address == `HISC_OFS_SET_STATUS);
  assign dropWr = commit && (address == `HISC_OFS_CLR_STATUS || address == `HISC_OFS_ENABLE_CLR);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence sTaken;
    (read || write) && waitrequest;
  endsequence
  // Full clear with no event racing it
  sequence sClrAll;
    dropWr && address == `HISC_OFS_CLR_STATUS && writedata[26:0] == 27'h7FFFFFF
      && byteenable == 4'hF && eventPulse == 27'h0000000;
  endsequence
  chk_one_wait: assert property (sTaken |=> !waitrequest ##1 waitrequest)
    else $error("access not answered after one wait");
  chk_wait_cause: assert property ($fell(waitrequest) |-> $past(read || write))
    else $error("answer without request");
  chk_clr_reads_zero: assert property (read && waitrequest && address == `HISC_OFS_CLR_STATUS |=> readdata == 32'h0)
    else $error("clear register read not zero");
  chk_rsvd_zero: assert property (readdata[31:27] == 5'h00)
    else $error("reserved read bits set");
  chk_data_hold: assert property (!(read && waitrequest) |=> $stable(readdata))
    else $error("read data moved without read");
  chk_irq_rise: assert property ($rose(irqRequest) |-> $past(eventPulse != 27'h0 || raiseWr, 2))
    else $error("request rose without cause");
  chk_irq_fall: assert property ($fell(irqRequest) |-> $past(dropWr, 2))
    else $error("request fell without clear");
  chk_clr_all_quiet: assert property (sClrAll |-> ##2 !irqRequest)
    else $error("request high after full clear");
endmodule
////////////////////////////////////////////////////////////////
bind hisc_irq_ctrl hisc_irq_ctrl_properties i_props (.clock(clock), .reset_n(reset_n),
  .address(address), .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .eventPulse(eventPulse), .irqRequest(irqRequest));
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the interrupt status and clear registers
`default_nettype none
`include "hisc_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic [13:0] address = 14'h0000;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [3:0]  byteenable = 4'hF;
  logic [31:0] writedata = 32'h00000000;
  logic [26:0] eventPulse = 27'h0000000;
  wire  [31:0] readdata;
  wire         waitrequest;
  wire         irqRequest;
  logic [31:0] q;
  int          mismatches = 0;
  int          comparisons = 0;
  localparam logic [31:0] ALL = 32'h07FFFFFF;
  always #50 clock = ~clock;
  hisc_irq_ctrl i_dut (.clock(clock), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .eventPulse(eventPulse), .irqRequest(irqRequest));
  ////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic acc(input logic w, input logic [13:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    write <= w;
    read <= !w;
    address <= a;
    writedata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic rdc(input logic [13:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk("readdata", e, q);
  endtask
  // Request trails a commit by one further edge
  task automatic irq(input logic e);
    repeat (2) @(posedge clock);
    chk("irqRequest", {31'h0, e}, {31'h0, irqRequest});
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (2000) @(posedge clock);
    mismatches++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rdc(`HISC_OFS_STATUS, 32'h0);
    rdc(`HISC_OFS_CLR_STATUS, 32'h0);
    rdc(14'h0000, 32'h0);
    for (int b = 0; b < 27; b++) begin
      acc(1'b1, `HISC_OFS_SET_STATUS, ALL);
      acc(1'b1, `HISC_OFS_CLR_STATUS, 32'hF8000000 | (32'h1 << b));
      rdc(`HISC_OFS_STATUS, ALL & ~(32'h1 << b));
    end
    byteenable <= 4'h0;
    acc(1'b1, `HISC_OFS_CLR_STATUS, ALL);
    byteenable <= 4'hF;
    rdc(`HISC_OFS_STATUS, 32'h03FFFFFF);
    acc(1'b1, `HISC_OFS_CLR_STATUS, ALL);
    rdc(`HISC_OFS_STATUS, 32'h0);
    eventPulse <= ALL[26:0];
    acc(1'b1, `HISC_OFS_CLR_STATUS, ALL);
    eventPulse <= 27'h0;
    rdc(`HISC_OFS_STATUS, ALL);
    acc(1'b1, `HISC_OFS_CLR_STATUS, ALL);
    acc(1'b1, `HISC_OFS_ENABLE_SET, 32'h10);
    irq(1'b0);
    @(posedge clock);
    eventPulse <= 27'h0000010;
    @(posedge clock);
    eventPulse <= 27'h0;
    irq(1'b1);
    rdc(`HISC_OFS_PENDING, 32'h10);
    acc(1'b1, `HISC_OFS_CLR_STATUS, 32'h20);
    irq(1'b1);
    acc(1'b1, `HISC_OFS_CLR_STATUS, 32'h10);
    irq(1'b0);
    acc(1'b1, `HISC_OFS_SET_STATUS, 32'h30);
    irq(1'b1);
    acc(1'b1, `HISC_OFS_ENABLE_CLR, 32'h10);
    irq(1'b0);
    test_done();
  end
endmodule
`default_nettype wire
